// ==== cmp_control.sv ====
`timescale 1ns/1ps
// What this block does
// - shared register bits 7 and 6 mirror comparator one and two results.
// - reading shared register never touches the mismatch latches.
// - reference-source select 1 routes fixed reference, 0 routes the dac output.
// - chosen reference reaches noninverting input only via noninv_ref_select.
// - hysteresis enable bits drive each comparator's hysteresis control.
// - sync mode 1 registers result on timer clock edge, 0 passes through.
// - sync latch uses the prescaled timer clock, not the raw source.
// - sync capture happens on the same edge that increments the timer.
// - mirror bits read-only, six config bits read/write, all reset zero.
// - port reads return zero for every pin set as analog input.
// - output_polarity 1 inverts the reported result, 0 passes it.
// - noninv_ref_select 1 picks internal reference, 0 the external pin.
// - mismatch latch captures result on each control register 0 read or write.
module cmp_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic raw_out_one,
  input wire logic raw_out_two,
  input wire logic timer_tick,
  input wire logic [7:0] port_pins,
  output logic on_one,
  output logic on_two,
  output logic speed_one,
  output logic speed_two,
  output logic oe_one,
  output logic oe_two,
  output logic fixed_ref_to_one,
  output logic fixed_ref_to_two,
  output logic internal_ref_one,
  output logic internal_ref_two,
  output logic hysteresis_en_one,
  output logic hysteresis_en_two,
  output logic [1:0] channel_one,
  output logic [1:0] channel_two,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctl_one;
    logic [7:0] ctl_two;
    logic [7:0] shared;
    logic [1:0] mm_latch;
    logic [1:0] mm_prev;
    logic [1:0] status;
    logic [1:0] mask;
    logic [7:0] analog_sel;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] result;
    logic irq;
  } state_t;
  state_t q;
  state_t d;
  logic res_one;
  logic res_two;
  logic do_write;
  logic do_read;
  logic [1:0] mism;

  // ----------------------------------------
  // result paths
  // ----------------------------------------
  cmp_sync_latch u_one (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(raw_out_one),
    .tick(timer_tick),
    .sync_mode(q.shared[cmp_pkg::sync_one_bit]),
    .polarity(q.ctl_one[cmp_pkg::ctl_pol_bit]),
    .result(res_one)
  );
  cmp_sync_latch u_two (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(raw_out_two),
    .tick(timer_tick),
    .sync_mode(q.shared[cmp_pkg::sync_two_bit]),
    .polarity(q.ctl_two[cmp_pkg::ctl_pol_bit]),
    .result(res_two)
  );

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic en, input logic [7:0] wmask);
    merge = en ? ((old & ~wmask) | (wd & wmask)) : old;
  endfunction : merge

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    do_write = q.aw_held && q.w_held && !q.bvalid;
    do_read = s_axi_arvalid && !q.rvalid;
    d.result = {res_two, res_one};
    d.pin_s1 = port_pins;
    d.pin_s2 = q.pin_s1;
    // mismatch: latch vs current result, interrupt on rising edge of mismatch
    mism = q.mm_latch ^ q.result;
    d.mm_prev = mism;
    if (s_axi_awvalid && !q.aw_held)
    begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_held)
    begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bready && q.bvalid)
    begin
      d.bvalid = 1'b0;
    end
    if (s_axi_rready && q.rvalid)
    begin
      d.rvalid = 1'b0;
    end
    if (do_write)
    begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = cmp_pkg::resp_okay;
      case (q.aw_addr)
        cmp_pkg::one_control_addr:
        begin
          d.ctl_one = merge(q.ctl_one, q.w_data[7:0], q.w_strb[0], cmp_pkg::ctl_write_mask);
          d.mm_latch[0] = q.result[0];
        end
        cmp_pkg::two_control_addr:
        begin
          d.ctl_two = merge(q.ctl_two, q.w_data[7:0], q.w_strb[0], cmp_pkg::ctl_write_mask);
          d.mm_latch[1] = q.result[1];
        end
        cmp_pkg::shared_control_addr:
          d.shared = merge(q.shared, q.w_data[7:0], q.w_strb[0], cmp_pkg::shared_write_mask);
        cmp_pkg::irq_status_addr:
          if (q.w_strb[0])
          begin
            d.status = q.status & ~q.w_data[1:0];
          end
        cmp_pkg::irq_mask_addr:
          if (q.w_strb[0])
          begin
            d.mask = q.w_data[1:0];
          end
        cmp_pkg::analog_select_addr:
          d.analog_sel = merge(q.analog_sel, q.w_data[7:0], q.w_strb[0], 8'hFF);
        cmp_pkg::port_value_addr:
          d.bresp = cmp_pkg::resp_okay;
        default:
          d.bresp = cmp_pkg::resp_slverr;
      endcase
    end
    if (do_read)
    begin
      d.rvalid = 1'b1;
      d.rresp = cmp_pkg::resp_okay;
      d.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        cmp_pkg::one_control_addr:
        begin
          d.rdata[7:0] = q.ctl_one;
          d.rdata[cmp_pkg::ctl_result_bit] = q.result[0];
          d.mm_latch[0] = q.result[0];
        end
        cmp_pkg::two_control_addr:
        begin
          d.rdata[7:0] = q.ctl_two;
          d.rdata[cmp_pkg::ctl_result_bit] = q.result[1];
          d.mm_latch[1] = q.result[1];
        end
        cmp_pkg::shared_control_addr:
        begin
          // no latch update here: software may poll both results freely
          d.rdata[7:0] = q.shared;
          d.rdata[cmp_pkg::mirror_one_bit] = q.result[0];
          d.rdata[cmp_pkg::mirror_two_bit] = q.result[1];
        end
        cmp_pkg::irq_status_addr:
          d.rdata[1:0] = q.status;
        cmp_pkg::irq_mask_addr:
          d.rdata[1:0] = q.mask;
        cmp_pkg::port_value_addr:
          d.rdata[7:0] = q.pin_s2 & ~q.analog_sel;
        cmp_pkg::analog_select_addr:
          d.rdata[7:0] = q.analog_sel;
        default:
          d.rresp = cmp_pkg::resp_slverr;
      endcase
    end
    // set wins over a same-cycle clear
    d.status = d.status | (mism & ~q.mm_prev);
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = !q.aw_held;
  assign s_axi_wready = !q.w_held;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign on_one = q.ctl_one[cmp_pkg::ctl_on_bit];
  assign on_two = q.ctl_two[cmp_pkg::ctl_on_bit];
  assign oe_one = q.ctl_one[cmp_pkg::ctl_oe_bit];
  assign oe_two = q.ctl_two[cmp_pkg::ctl_oe_bit];
  assign speed_one = q.ctl_one[cmp_pkg::ctl_speed_bit];
  assign speed_two = q.ctl_two[cmp_pkg::ctl_speed_bit];
  assign fixed_ref_to_one = q.shared[cmp_pkg::rsel_one_bit];
  assign fixed_ref_to_two = q.shared[cmp_pkg::rsel_two_bit];
  assign internal_ref_one = q.ctl_one[cmp_pkg::ctl_ref_bit];
  assign internal_ref_two = q.ctl_two[cmp_pkg::ctl_ref_bit];
  assign hysteresis_en_one = q.shared[cmp_pkg::hys_one_bit];
  assign hysteresis_en_two = q.shared[cmp_pkg::hys_two_bit];
  assign channel_one = q.ctl_one[1:0];
  assign channel_two = q.ctl_two[1:0];
  assign irq = q.irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  mirror_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && !q.rvalid && s_axi_araddr == cmp_pkg::shared_control_addr)
    |=> s_axi_rdata[7:6] == {$past(q.result[0]), $past(q.result[1])})
    else $error("mirror bits wrong");
  shared_no_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_read && s_axi_araddr == cmp_pkg::shared_control_addr && !do_write) |=> $stable(q.mm_latch))
    else $error("shared read touched latch");
  ref_route_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fixed_ref_to_one == q.shared[5] && fixed_ref_to_two == q.shared[4])
    else $error("ref select wrong");
  hys_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && q.aw_addr == cmp_pkg::shared_control_addr && q.w_strb[0])
    |=> hysteresis_en_one == $past(q.w_data[3]) && hysteresis_en_two == $past(q.w_data[2]))
    else $error("hysteresis not written");
  mirror_ro_a: assert property (@(posedge aclk) disable iff (!aresetn)
    q.shared[7:6] == 2'h0)
    else $error("mirror bits stored");
  port_analog_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_read && s_axi_araddr == cmp_pkg::port_value_addr) |=> (s_axi_rdata[7:0] & $past(q.analog_sel)) == 8'h00)
    else $error("analog pin read nonzero");
  ctl_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_read && s_axi_araddr == cmp_pkg::one_control_addr) |=> q.mm_latch[0] == $past(q.result[0]))
    else $error("latch not captured");
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(q.status & q.mask))
    else $error("irq mismatch");
  sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.shared[1] && $past(q.shared[1]) && !$past(timer_tick) && $past(q.ctl_one[4]) == q.ctl_one[4]) |-> $stable(res_one))
    else $error("sync result moved without tick");
endmodule : cmp_control

// ==== cmp_pkg.sv ====
package cmp_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] one_control_addr = 8'h00;
  localparam logic [7:0] two_control_addr = 8'h04;
  localparam logic [7:0] shared_control_addr = 8'h08;
  localparam logic [7:0] irq_status_addr = 8'h0C;
  localparam logic [7:0] irq_mask_addr = 8'h10;
  localparam logic [7:0] port_value_addr = 8'h14;
  localparam logic [7:0] analog_select_addr = 8'h18;
  // ----------------------------------------
  // control register 0 fields
  // ----------------------------------------
  localparam int ctl_on_bit = 7;
  localparam int ctl_result_bit = 6;
  localparam int ctl_oe_bit = 5;
  localparam int ctl_pol_bit = 4;
  localparam int ctl_speed_bit = 3;
  localparam int ctl_ref_bit = 2;
  localparam logic [7:0] ctl_write_mask = 8'hBF;
  localparam logic [7:0] ctl_reset = 8'h00;
  // ----------------------------------------
  // shared register fields
  // ----------------------------------------
  localparam int mirror_one_bit = 7;
  localparam int mirror_two_bit = 6;
  localparam int rsel_one_bit = 5;
  localparam int rsel_two_bit = 4;
  localparam int hys_one_bit = 3;
  localparam int hys_two_bit = 2;
  localparam int sync_one_bit = 1;
  localparam int sync_two_bit = 0;
  localparam logic [7:0] shared_write_mask = 8'h3F;
  localparam logic [7:0] shared_reset = 8'h00;
  localparam logic [1:0] irq_reset = 2'h0;
  localparam logic [7:0] port_reset = 8'h00;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : cmp_pkg

// ==== cmp_sync_latch.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// one output path: sync, tmr edge latch
// ----------------------------------------
module cmp_sync_latch (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raw_in,
  input wire logic tick,
  input wire logic sync_mode,
  input wire logic polarity,
  output logic result
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic latch;
  } state_t;
  state_t state_q;
  state_t state_d;
  logic adjusted;

  always_comb
  begin
    state_d = state_q;
    state_d.s1 = raw_in;
    state_d.s2 = state_q.s1;
    if (tick)
    begin
      state_d.latch = adjusted;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign adjusted = state_q.s2 ^ polarity;
  assign result = sync_mode ? state_q.latch : adjusted;
endmodule : cmp_sync_latch

// ==== cmp_analog_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// analog cores and timer prescaler stand-in
// ----------------------------------------
module cmp_analog_model (
  input wire logic aclk,
  output logic raw_out_one,
  output logic raw_out_two,
  output logic timer_tick
);
  initial
  begin
    raw_out_one = 1'b0;
    raw_out_two = 1'b0;
    timer_tick = 1'b0;
  end
  // levels only move, no glitches: the block resyncs them anyway
  task set_out(input logic a, input logic b);
    raw_out_one <= a;
    raw_out_two <= b;
  endtask : set_out
  // prescaled increment edge, one aclk wide, never the raw source
  task tick();
    @(posedge aclk);
    timer_tick <= 1'b1;
    @(posedge aclk);
    timer_tick <= 1'b0;
  endtask : tick
endmodule : cmp_analog_model

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, raw_one, raw_two, tick;
  logic [7:0] awaddr, araddr, port_pins;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [5:0] pins;
  logic [9:0] ctl_pins;
  logic [1:0] wresp;
  int n_fail, n_compared;
  logic [34:0] notes [$];
  cmp_analog_model pm (.aclk(aclk), .raw_out_one(raw_one), .raw_out_two(raw_two), .timer_tick(tick));
  cmp_control uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .raw_out_one(raw_one),
    .raw_out_two(raw_two), .timer_tick(tick), .port_pins(port_pins), .on_one(ctl_pins[9]),
    .on_two(ctl_pins[4]), .speed_one(ctl_pins[7]), .speed_two(ctl_pins[2]), .oe_one(ctl_pins[8]),
    .oe_two(ctl_pins[3]), .fixed_ref_to_one(pins[5]),
    .fixed_ref_to_two(pins[4]), .hysteresis_en_one(pins[3]), .hysteresis_en_two(pins[2]),
    .internal_ref_one(pins[1]), .internal_ref_two(pins[0]), .channel_one(ctl_pins[6:5]),
    .channel_two(ctl_pins[1:0]), .irq(irq));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task final_report();
    if (n_fail == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task cmp_val(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t level got %h want %h", $time, got, exp);
    end
  endtask : cmp_val
  task cmp_rd(input logic [34:0] e);
    n_compared++;
    if (rresp !== e[33:32] || (e[34] && rdata !== e[31:0]))
    begin
      n_fail++;
      $display("[ERR] %0t read got %h/%h want %h", $time, rresp, rdata, e[33:0]);
    end
  endtask : cmp_rd
  // a response never seen within 50 edges counts as a failure, not a hang
  task wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        wresp = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (i == 50) n_fail++;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] d, input logic c, input logic [1:0] r);
    int i;
    @(posedge aclk);
    notes.push_back({c, r, 24'h000000, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (i == 50) n_fail++;
  endtask : rd
  // ----------------------------------------
  // read monitor
  // ----------------------------------------
  always @(posedge aclk)
    if (rvalid === 1'b1 && rready === 1'b1 && notes.size() > 0)
      cmp_rd(notes.pop_front());
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] v, p;
    logic [1:0] k;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    port_pins = 8'h00;
    n_fail = 0;
    n_compared = 0;
    v = $urandom(32'h7E3C);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(cmp_pkg::shared_control_addr, 8'h00, 1'b1, cmp_pkg::resp_okay);
    rd(cmp_pkg::one_control_addr, 8'h00, 1'b1, cmp_pkg::resp_okay);
    repeat (4)
    begin
      v = $urandom;
      wr(cmp_pkg::shared_control_addr, v);
      rd(cmp_pkg::shared_control_addr, {2'b00, v[5:0]}, 1'b1, cmp_pkg::resp_okay);
      cmp_val({2'b00, pins}, {2'b00, v[5:2], 2'b00});
    end
    wr(cmp_pkg::shared_control_addr, 8'h00);
    for (k = 2'b10; k != 2'b00; k = k >> 1)
    begin
      pm.set_out(k[1], k[0]);
      repeat (6) @(posedge aclk);
      rd(cmp_pkg::shared_control_addr, {k, 6'h00}, 1'b1, cmp_pkg::resp_okay);
    end
    // sync latch starts at zero and only moves on a tick
    wr(cmp_pkg::shared_control_addr, 8'h03);
    rd(cmp_pkg::shared_control_addr, 8'h03, 1'b1, cmp_pkg::resp_okay);
    pm.tick();
    rd(cmp_pkg::shared_control_addr, 8'h43, 1'b1, cmp_pkg::resp_okay);
    pm.set_out(1'b1, 1'b0);
    repeat (6) @(posedge aclk);
    rd(cmp_pkg::shared_control_addr, 8'h43, 1'b1, cmp_pkg::resp_okay);
    pm.tick();
    rd(cmp_pkg::shared_control_addr, 8'h83, 1'b1, cmp_pkg::resp_okay);
    wr(cmp_pkg::shared_control_addr, 8'h00);
    wr(cmp_pkg::one_control_addr, 8'h50);
    repeat (6) @(posedge aclk);
    rd(cmp_pkg::shared_control_addr, 8'h00, 1'b1, cmp_pkg::resp_okay);
    rd(cmp_pkg::one_control_addr, 8'h10, 1'b1, cmp_pkg::resp_okay);
    wr(cmp_pkg::one_control_addr, 8'h04);
    cmp_val({2'b00, pins}, 8'h02);
    rd(cmp_pkg::one_control_addr, 8'h44, 1'b1, cmp_pkg::resp_okay);
    pm.set_out(1'b0, 1'b0);
    repeat (6) @(posedge aclk);
    rd(cmp_pkg::one_control_addr, 8'h04, 1'b1, cmp_pkg::resp_okay);
    wr(cmp_pkg::irq_status_addr, 8'h03);
    wr(cmp_pkg::irq_mask_addr, 8'h01);
    pm.set_out(1'b1, 1'b0);
    repeat (6) @(posedge aclk);
    cmp_val({7'h00, irq}, 8'h01);
    rd(cmp_pkg::irq_status_addr, 8'h01, 1'b1, cmp_pkg::resp_okay);
    wr(cmp_pkg::irq_status_addr, 8'h01);
    repeat (3) @(posedge aclk);
    cmp_val({7'h00, irq}, 8'h00);
    rd(cmp_pkg::shared_control_addr, 8'h80, 1'b1, cmp_pkg::resp_okay);
    pm.set_out(1'b0, 1'b0);
    repeat (6) @(posedge aclk);
    rd(cmp_pkg::irq_status_addr, 8'h00, 1'b1, cmp_pkg::resp_okay);
    pm.set_out(1'b1, 1'b0);
    wr(cmp_pkg::irq_mask_addr, 8'h00);
    repeat (6) @(posedge aclk);
    cmp_val({7'h00, irq}, 8'h00);
    rd(cmp_pkg::irq_status_addr, 8'h01, 1'b1, cmp_pkg::resp_okay);
    v = $urandom;
    p = $urandom;
    wr(cmp_pkg::analog_select_addr, v);
    port_pins <= p;
    repeat (4) @(posedge aclk);
    rd(cmp_pkg::port_value_addr, p & ~v, 1'b1, cmp_pkg::resp_okay);
    // port value is read-only: a write answers okay and leaves the pins alone
    wr(cmp_pkg::port_value_addr, 8'hFF);
    cmp_val({6'h00, wresp}, {6'h00, cmp_pkg::resp_okay});
    rd(cmp_pkg::port_value_addr, p & ~v, 1'b1, cmp_pkg::resp_okay);
    // both control registers with random fields; comparator one still sees a high raw level
    v = $urandom;
    p = $urandom;
    wr(cmp_pkg::one_control_addr, v);
    wr(cmp_pkg::two_control_addr, p);
    cmp_val({2'b00, ctl_pins[9:7], pins[1], ctl_pins[6:5]}, {2'b00, v[7], v[5], v[3:0]});
    cmp_val({2'b00, ctl_pins[4:2], pins[0], ctl_pins[1:0]}, {2'b00, p[7], p[5], p[3:0]});
    rd(cmp_pkg::one_control_addr, {v[7], ~v[4], v[5:0]}, 1'b1, cmp_pkg::resp_okay);
    rd(cmp_pkg::two_control_addr, {p[7], p[4], p[5:0]}, 1'b1, cmp_pkg::resp_okay);
    // a write latches the old result first, so flipping polarity raises a mismatch
    wr(cmp_pkg::irq_status_addr, 8'h03);
    wr(cmp_pkg::two_control_addr, p ^ 8'h10);
    repeat (6) @(posedge aclk);
    rd(cmp_pkg::irq_status_addr, 8'h02, 1'b1, cmp_pkg::resp_okay);
    wr(cmp_pkg::irq_mask_addr, 8'h02);
    cmp_val({7'h00, irq}, 8'h01);
    rd(8'h1C, 8'h00, 1'b0, cmp_pkg::resp_slverr);
    wr(8'h1C, 8'hFF);
    cmp_val({6'h00, wresp}, {6'h00, cmp_pkg::resp_slverr});
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule : tb_top
